// File: rtl/pwmt_cfg.svh
// Register map, field positions, reset values for the PWM timer.
// Included by the timer file only, not by the prescaler; definitions only.
`ifndef PWMT_CFG_SVH
`define PWMT_CFG_SVH
`define PWMT_OFF_CTRL   8'h00
`define PWMT_OFF_CNT    8'h04
`define PWMT_OFF_MATCH  8'h08
`define PWMT_OFF_RELOAD 8'h0c
`define PWMT_OFF_STAT   8'h10
`define PWMT_OFF_MASK   8'h14
`define PWMT_CTRL_EN    0
`define PWMT_CTRL_POL   1
`define PWMT_CTRL_PRE_LO 4
`define PWMT_CTRL_PRE_HI 6
`define PWMT_CTRL_RST   8'h00
`define PWMT_CNT_RST    16'h0001
`define PWMT_MATCH_RST  16'h0000
`define PWMT_RELOAD_RST 16'h0000
`define PWMT_RELOAD_VAL 16'h0001
`define PWMT_STAT_RELOAD 0
`define PWMT_STAT_MATCH  1
`endif

// File: rtl/pwmt_pkg.sv
// Types shared by the PWM timer files.
// Assumes nothing of its surroundings.
package pwmt_pkg;
  typedef logic [15:0] pwmt_word_t;
  typedef logic [2:0]  pwmt_pre_t;
  typedef enum logic [1:0]
  {
    PWMT_IDLE   = 2'b01,
    PWMT_ACCESS = 2'b10
  } pwmt_bus_st_t;
endpackage

// File: rtl/pwmt_prescaler.sv
// Prescaler: one-cycle tick every 2**pre ref_clk cycles while running.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module pwmt_prescaler
  import pwmt_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              run,
  input  wire pwmt_pkg::pwmt_pre_t pre,
  output logic                   tick
);
  import pwmt_pkg::*;

  logic [6:0] div_q;
  logic [6:0] div_d;
  logic       tick_q;
  logic       tick_d;
  logic [6:0] limit;

  always_comb
  begin
    limit  = 7'((8'h01 << pre) - 8'h01);
    div_d  = div_q;
    tick_d = 1'b0;
    if (!run)
    begin
      div_d = 7'h00;
    end
    else if (div_q >= limit)
    begin
      div_d  = 7'h00;
      tick_d = 1'b1;
    end
    else
    begin
      div_d = div_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q  <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // pwmt_prescaler

// File: rtl/pwmt_timer.sv
// PWM single-output timer with an AHB-Lite register slave.
// Assumes one ref_clk domain; the GPIO mux outside selects timerOut.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "pwmt_cfg.svh"
// Behaviour
// - Counting ticks come from ref_clk through the prescaler only.
// - A 16-bit up-counter is compared against the 16-bit match value.
// - Equality with match toggles the output and counting goes on, unless the count also equals reload.
// - Reaching the reload value sets the reload interrupt status.
// - At reload the counter becomes 0001H and counts on the next tick.
// - With polarity 1 the output starts high, falls at match, rises at reload.
// - With polarity 0 the output starts low, rises at match, falls at reload.
// - A written count only seeds the first period; later ones start at 0001H.
module pwmt_timer
  import pwmt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             timerOut,
  output logic             irq
);
  import pwmt_pkg::*;

  logic         ctrlEn_q;
  logic         ctrlEn_d;
  logic         ctrlPol_q;
  logic         ctrlPol_d;
  pwmt_pre_t    ctrlPre_q;
  pwmt_pre_t    ctrlPre_d;
  pwmt_word_t   count_q;
  pwmt_word_t   count_d;
  pwmt_word_t   match_q;
  pwmt_word_t   match_d;
  pwmt_word_t   reload_q;
  pwmt_word_t   reload_d;
  logic         out_q;
  logic         out_d;
  logic [1:0]   stat_q;
  logic [1:0]   stat_d;
  logic [1:0]   mask_q;
  logic [1:0]   mask_d;
  logic         irq_q;
  logic         irq_d;
  pwmt_bus_st_t st_q;
  pwmt_bus_st_t st_d;
  logic [7:0]   addr_q;
  logic [7:0]   addr_d;
  logic         wr_q;
  logic         wr_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  logic         tick;
  logic         hitMatch;
  logic         hitReload;
  logic         addrPhase;
  logic         doWrite;
  logic         doRead;

  function automatic logic [31:0] readMux
  (
    input logic [7:0] a,
    input logic       en,
    input logic       pol,
    input pwmt_pre_t  pre,
    input pwmt_word_t cnt,
    input pwmt_word_t mat,
    input pwmt_word_t rel,
    input logic [1:0] st,
    input logic [1:0] msk,
    input logic       o
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `PWMT_OFF_CTRL:
      begin
        r[`PWMT_CTRL_EN]  = en;
        r[`PWMT_CTRL_POL] = pol;
        r[`PWMT_CTRL_PRE_HI:`PWMT_CTRL_PRE_LO] = pre;
        r[8] = o;
      end
      `PWMT_OFF_CNT:    r[15:0] = cnt;
      `PWMT_OFF_MATCH:  r[15:0] = mat;
      `PWMT_OFF_RELOAD: r[15:0] = rel;
      `PWMT_OFF_STAT:   r[1:0]  = st;
      `PWMT_OFF_MASK:   r[1:0]  = msk;
      default:          r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Prescaled system clock only; no external count input
  pwmt_prescaler u_pre
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (ctrlEn_q),
    .pre     (ctrlPre_q),
    .tick    (tick)
  );

  // Bus slave: always zero wait states, OKAY only
  assign addrPhase = hsel && hready && htrans[1];
  assign doWrite   = (st_q == PWMT_ACCESS) && wr_q;
  assign doRead    = addrPhase && !hwrite;

  always_comb
  begin
    st_d    = PWMT_IDLE;
    addr_d  = addr_q;
    wr_d    = 1'b0;
    rdata_d = rdata_q;
    if (addrPhase)
    begin
      st_d   = PWMT_ACCESS;
      addr_d = haddr[7:0];
      wr_d   = hwrite;
    end
    if (doRead)
    begin
      rdata_d = readMux(haddr[7:0], ctrlEn_q, ctrlPol_q, ctrlPre_q,
                        count_q, match_q, reload_q, stat_q, mask_q,
                        out_q);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q    <= PWMT_IDLE;
      addr_q  <= 8'h00;
      wr_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      wr_q    <= wr_d;
      rdata_q <= rdata_d;
    end
  end

  // Timer core
  assign hitReload = ctrlEn_q && tick && (count_q == reload_q);
  assign hitMatch  = ctrlEn_q && tick && (count_q == match_q);

  always_comb
  begin
    ctrlEn_d  = ctrlEn_q;
    ctrlPol_d = ctrlPol_q;
    ctrlPre_d = ctrlPre_q;
    count_d   = count_q;
    match_d   = match_q;
    reload_d  = reload_q;
    mask_d    = mask_q;
    out_d     = out_q;
    stat_d    = stat_q;
    if (!ctrlEn_q)
    begin
      out_d = ctrlPol_q;
    end
    else if (tick)
    begin
      if (hitReload)
      begin
        count_d = `PWMT_RELOAD_VAL;
        out_d   = ctrlPol_q;
      end
      else
      begin
        count_d = count_q + 16'h0001;
        if (hitMatch)
        begin
          out_d = ~out_q;
        end
      end
    end
    // Read clears status; a new event in the same cycle still wins
    if (doRead && (haddr[7:0] == `PWMT_OFF_STAT))
    begin
      stat_d = 2'b00;
    end
    if (hitReload)
    begin
      stat_d[`PWMT_STAT_RELOAD] = 1'b1;
    end
    if (hitMatch && !hitReload)
    begin
      stat_d[`PWMT_STAT_MATCH] = 1'b1;
    end
    if (doWrite)
    begin
      unique case (addr_q)
        `PWMT_OFF_CTRL:
        begin
          ctrlEn_d  = hwdata[`PWMT_CTRL_EN];
          ctrlPol_d = hwdata[`PWMT_CTRL_POL];
          ctrlPre_d = hwdata[`PWMT_CTRL_PRE_HI:`PWMT_CTRL_PRE_LO];
        end
        `PWMT_OFF_CNT:    count_d  = hwdata[15:0];
        `PWMT_OFF_MATCH:  match_d  = hwdata[15:0];
        `PWMT_OFF_RELOAD: reload_d = hwdata[15:0];
        `PWMT_OFF_MASK:   mask_d   = hwdata[1:0];
        default:          mask_d   = mask_q;
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrlEn_q  <= 1'b0;
      ctrlPol_q <= 1'b0;
      ctrlPre_q <= 3'h0;
      count_q   <= `PWMT_CNT_RST;
      match_q   <= `PWMT_MATCH_RST;
      reload_q  <= `PWMT_RELOAD_RST;
      mask_q    <= 2'b00;
      out_q     <= 1'b0;
      stat_q    <= 2'b00;
      irq_q     <= 1'b0;
    end
    else
    begin
      ctrlEn_q  <= ctrlEn_d;
      ctrlPol_q <= ctrlPol_d;
      ctrlPre_q <= ctrlPre_d;
      count_q   <= count_d;
      match_q   <= match_d;
      reload_q  <= reload_d;
      mask_q    <= mask_d;
      out_q     <= out_d;
      stat_q    <= stat_d;
      irq_q     <= irq_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign timerOut  = out_q;
  assign irq       = irq_q;
endmodule // pwmt_timer

// File: tb/pwmt_timer_asserts.sv
// Port checker for the PWM timer, bound to its top module.
// Assumes word register writes and the single ref_clk domain.
`timescale 1ns/1ns
module pwmt_timer_asserts
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        timerOut,
  input wire logic        irq
);
  logic [7:0] wa_d, wa_q, ctl_d, ctl_q, gap_d, gap_q;
  logic [1:0] msk_d, msk_q;
  logic       out_q;
  always_comb
  begin
    wa_d  = (hsel && htrans[1] && hwrite) ? haddr[7:0] : 8'hff;
    ctl_d = (wa_q == 8'h00) ? hwdata[7:0] : ctl_q;
    msk_d = (wa_q == 8'h14) ? hwdata[1:0] : msk_q;
    gap_d = (timerOut != out_q) ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
  end
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {wa_q, ctl_q, msk_q, gap_q, out_q} <= {8'hff, 8'h0, 2'b0, 8'h0, 1'b0};
    else
      {wa_q, ctl_q, msk_q, gap_q, out_q} <= {wa_d, ctl_d, msk_d, gap_d, timerOut};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_off_level: assert property (
    (!ctl_q[0] && $stable(ctl_q))[*2] |-> timerOut == ctl_q[1])
    else $error("idle level wrong");
  a_off_quiet: assert property (
    (!ctl_q[0] && $stable(ctl_q))[*3] |-> $stable(timerOut))
    else $error("output moved while off");
  a_tick_spacing: assert property (
    $changed(timerOut) && ctl_q[0] |-> gap_q >= (8'h1 << ctl_q[6:4]) - 8'h1)
    else $error("step faster than tick");
  // Two back: a disable may land one edge after the event
  a_irq_when_on: assert property (
    $rose(irq) |-> $past(ctl_q[0], 2))
    else $error("irq while off");
  a_reload_level: assert property (
    $rose(irq) && msk_q == 2'b01 |-> timerOut == ctl_q[1])
    else $error("reload level wrong");
  a_match_flip: assert property (
    $rose(irq) && msk_q == 2'b10 |-> timerOut != ctl_q[1])
    else $error("no flip at match");
  // A status read taken one edge after the reload may clear it legally
  a_reload_irq: assert property (
    $changed(timerOut) && ctl_q[0] && timerOut == ctl_q[1] && msk_q[0]
    && !(hsel && htrans[1] && !hwrite && haddr[7:0] == 8'h10)
    |=> irq) else $error("no irq at reload");
  a_irq_masked: assert property (
    (msk_q == 2'b00)[*3] |-> !irq)
    else $error("masked irq");
  cover property ($rose(irq) && msk_q == 2'b01);
  cover property ($rose(irq) && msk_q == 2'b10);
  cover property ($fell(timerOut) && ctl_q[0]);
endmodule // pwmt_timer_asserts
bind pwmt_timer pwmt_timer_asserts u_pwmt_timer_asserts
(
  .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .timerOut, .irq
);

// File: tb/pwmt_load.sv
// Load on the timer output pin: measures its high and low widths.
// Assumes the pin is seen only at ref_clk edges.
`timescale 1ns/1ns
module pwmt_load
(
  input  wire logic ref_clk,
  input  wire logic pinLevel,
  output int        highLen,
  output int        lowLen
);
  int   run_q = 0;
  logic last_q = 1'b0;
  always @(posedge ref_clk)
  begin
    if (pinLevel != last_q)
    begin
      if (last_q)
        highLen <= run_q + 1;
      else
        lowLen <= run_q + 1;
      run_q <= 0;
    end
    else
      run_q <= run_q + 1;
    last_q <= pinLevel;
  end
endmodule // pwmt_load

// File: tb/tb.sv
// Self-checking bench for the PWM timer over AHB-Lite.
// Assumes the output pin feeds the pulse-width load model.
`timescale 1ns/1ns
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errCount++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, timerOut, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          errCount, checkCount, highLen, lowLen;
  pwmt_timer u_pwmt_timer
  (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timerOut, .irq
  );
  pwmt_load u_pwmt_load (.ref_clk, .pinLevel(timerOut), .highLen, .lowLen);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    {hsel, haddr, hwrite, htrans} <= {1'b1, 24'h0, a, w, 2'b10};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic run_pwm(input logic pol, input logic [2:0] pre,
                         input int start, mat, rel, input logic [1:0] msk);
    logic [31:0] ctl;
    ctl = {25'h0, pre, 2'b00, pol, 1'b0};
    bus(8'h00, 1'b1, ctl);
    bus(8'h04, 1'b1, 32'(start));
    bus(8'h08, 1'b1, 32'(mat));
    bus(8'h0c, 1'b1, 32'(rel));
    bus(8'h10, 1'b0, 32'h0);
    bus(8'h14, 1'b1, {30'h0, msk});
    bus(8'h00, 1'b1, ctl | 32'h1);
    // Seeded start near reload must bring the first reload early
    for (int i = 0; i < ((rel - start + 2) << pre) + 8 && !irq; i++)
      @(posedge ref_clk);
    if (msk[0])
      `CHK(irq, 1'b1)
    repeat ((3 * rel << pre) + 8) @(posedge ref_clk);
    `CHK(pol ? highLen : lowLen, mat << pre)
    `CHK(pol ? lowLen : highLen, (rel - mat) << pre)
    `CHK(irq, msk != 2'b00)
    rdchk(8'h10, 32'h3);
    bus(8'h00, 1'b1, ctl);
    repeat (4) @(posedge ref_clk);
    `CHK(timerOut, pol)
    $display("test pwm pol %0d pre %0d done", pol, pre);
  endtask
  task automatic test_reset;
    `CHK(timerOut, 1'b0)
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h1);
    rdchk(8'h18, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_low_fast;
    run_pwm(1'b0, 3'd0, 1, 3, 7, 2'b01);
  endtask
  task automatic test_high_seeded;
    run_pwm(1'b1, 3'd2, 5, 2, 5, 2'b10);
  endtask
  task automatic test_masked;
    run_pwm(1'b1, 3'd1, 1, 1, 4, 2'b00);
  endtask
  task automatic test_low_seeded;
    run_pwm(1'b0, 3'd3, 6, 4, 6, 2'b01);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    test_reset();
    test_low_fast();
    test_high_seeded();
    test_masked();
    test_low_seeded();
    tally_and_finish();
  end
  // Whole run is a few hundred cycles; this allows ample slack
  initial
  begin
    #5000000;
    errCount++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule // tb
